//--- hdl/acq_channel.sv
/*
  acq_channel: one acquisition channel with input selector, tuned
  downconverter, decimating filter, phase/gain correction, power meter with
  threshold detector, gate-bounded capture into a FIFO and metadata per gate.
  Assumes converter data, gate and sync arrive with the sample clock i_clock,
  and software uses APB on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - the source of the channel is any one of eight converter inputs or the test generator.
// - the buffer runs either continuously as a FIFO or as a one-shot capture.
// - in gate mode a transfer's length is the number of words taken while the gate was high.
// - each transfer may produce metadata with channel id, sample time stamp and length.
// - a 32-bit tuning word sets the local oscillator from zero to the sample rate.
// - the decimation factor is programmable from 2 to 32768.
// - the channel tags its output with one of four board bandwidth slots.
// - the decimating filter uses a loadable set of 18-bit coefficients.
// - the default coefficient set is a flat window, equal weights on every tap, an integrate and dump.
// - output samples come at one per decimation period as 24-bit or 16-bit I and Q.
// - phase and gain correction follow decimation and precede the power meter.
// - average power is computed over an interval of up to 8192 samples.
// - the latest average power is readable by software.
// - crossings of a programmable power threshold raise an alert.
// - gate and sync come from the timing bus and the gate bounds acquisition.
module acq_channel #(
  parameter logic [7:0] CHANNEL_ID = 8'h00,
  parameter int         NCOEF      = 32,
  parameter int         FIFO_DEPTH = 32
) (
  // clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  // converters and timing bus
  input  wire logic [127:0]  i_adc_data,
  input  wire logic          i_gate,
  input  wire logic          i_sync,
  // apb slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [11:0]   i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  // sample stream to the memory buffer
  output logic               o_data_valid,
  input  wire logic          i_data_ready,
  output logic      [47:0]   o_data,
  // metadata per transfer
  output logic               o_meta_valid,
  output logic      [7:0]    o_meta_chan,
  output logic      [31:0]   o_meta_time,
  output logic      [31:0]   o_meta_len,
  // alerts and tags
  output logic               o_power_alert,
  output logic      [1:0]    o_bw_slot
);
  import acq_pkg::*;

  localparam int CW = $clog2(NCOEF);

  // registers
  logic [10:0]      ctrl_q;
  logic [31:0]      tune_q;
  logic [15:0]      decim_q;
  logic [15:0]      gain_i_q;
  logic [15:0]      gain_q_q;
  logic [15:0]      phase_q;
  logic [3:0]       avg_q;
  logic [31:0]      thresh_q;
  logic [31:0]      power_q;
  logic [ST_W-1:0]  status_q;
  logic [17:0]      coef_q [NCOEF];

  // apb decode
  logic        setup;
  logic        wr_en;
  logic        coef_hit;
  logic [CW-1:0] coef_idx;
  logic [31:0] rd_d;
  logic        err_d;

  assign setup    = i_psel && !i_penable;
  assign wr_en    = o_pready && i_pwrite;
  assign coef_hit = (i_paddr[11:7] == OFS_COEF[11:7]) &&
                    ({1'b0, i_paddr[6:2]} < 6'(NCOEF));
  assign coef_idx = i_paddr[CW+1:2];

  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (coef_hit) begin
      rd_d = {14'h0000, coef_q[coef_idx]};
    end else begin
      unique case (i_paddr)
        OFS_CTRL:   rd_d = {21'h00_0000, ctrl_q};
        OFS_TUNE:   rd_d = tune_q;
        OFS_DECIM:  rd_d = {16'h0000, decim_q};
        OFS_GAIN:   rd_d = {gain_q_q, gain_i_q};
        OFS_PHASE:  rd_d = {16'h0000, phase_q};
        OFS_AVG:    rd_d = {28'h000_0000, avg_q};
        OFS_THRESH: rd_d = thresh_q;
        OFS_POWER:  rd_d = power_q;
        OFS_STATUS: rd_d = {28'h000_0000, status_q};
        default:    err_d = 1'b1;
      endcase
    end
  end

  // one wait-free access: data is captured in setup, ready in access
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_prdata  <= setup ? rd_d : 32'h0000_0000;
      o_pslverr <= setup && err_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q   <= CTRL_RST;
      tune_q   <= TUNE_RST;
      decim_q  <= DECIM_RST;
      gain_i_q <= GAIN_RST;
      gain_q_q <= GAIN_RST;
      phase_q  <= PHASE_RST;
      avg_q    <= AVG_RST;
      thresh_q <= THRESH_RST;
    end else begin
      ctrl_q[CTRL_REARM] <= 1'b0;
      if (wr_en) begin
        unique case (i_paddr)
          OFS_CTRL:   ctrl_q <= i_pwdata[10:0];
          OFS_TUNE:   tune_q <= i_pwdata;
          // out-of-range factors are clamped so the filter always dumps
          OFS_DECIM:  decim_q <= (i_pwdata < 32'(DECIM_MIN)) ? DECIM_MIN :
                                 (i_pwdata > 32'(DECIM_MAX)) ? DECIM_MAX :
                                 i_pwdata[15:0];
          OFS_GAIN: begin
            gain_i_q <= i_pwdata[15:0];
            gain_q_q <= i_pwdata[31:16];
          end
          OFS_PHASE:  phase_q <= i_pwdata[15:0];
          OFS_AVG:    avg_q <= (i_pwdata[3:0] > AVG_MAX) ? AVG_MAX :
                               i_pwdata[3:0];
          OFS_THRESH: thresh_q <= i_pwdata;
          default: ;
        endcase
      end
    end
  end

  // coefficients reset to a flat window, the default filter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int k = 0; k < NCOEF; k++) coef_q[k] <= COEF_RST;
    end else if (wr_en && coef_hit) begin
      coef_q[coef_idx] <= i_pwdata[17:0];
    end
  end

  // timing bus: two flops before use
  logic [1:0] gate_sync_q;
  logic [1:0] sync_sync_q;
  logic       gate_d1_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gate_sync_q <= 2'b00;
      sync_sync_q <= 2'b00;
      gate_d1_q   <= 1'b0;
    end else begin
      gate_sync_q <= {gate_sync_q[0], i_gate};
      sync_sync_q <= {sync_sync_q[0], i_sync};
      gate_d1_q   <= gate_sync_q[1];
    end
  end

  // input selector and test generator
  logic [15:0] test_q;
  logic [15:0] sample_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      test_q   <= 16'h0000;
      sample_q <= 16'h0000;
    end else begin
      test_q <= test_q + TEST_STEP;
      if (ctrl_q[CTRL_SEL_LSB +: CTRL_SEL_W] == SEL_TEST) begin
        sample_q <= test_q;
      end else begin
        sample_q <= i_adc_data[16*ctrl_q[CTRL_SEL_LSB +: 3] +: 16];
      end
    end
  end

  // local oscillator: coarse 16-point table, the trade is spur level for area
  function automatic logic signed [15:0] lo_sin(input logic [3:0] p);
    logic [15:0] v;
    // the half-wave table is symmetric, so p[2:0] indexes it directly
    unique case (p[2:0])
      3'h0: v = 16'h0000;
      3'h1: v = 16'h30FC;
      3'h2: v = 16'h5A82;
      3'h3: v = 16'h7642;
      3'h4: v = 16'h7FFF;
      3'h5: v = 16'h7642;
      3'h6: v = 16'h5A82;
      3'h7: v = 16'h30FC;
    endcase
    lo_sin = p[3] ? -$signed(v) : $signed(v);
  endfunction

  logic [31:0]        lo_phase_q;
  logic signed [15:0] mix_i_q;
  logic signed [15:0] mix_q_q;
  logic signed [31:0] prod_i;
  logic signed [31:0] prod_q;
  assign prod_i = $signed(sample_q) * lo_sin(lo_phase_q[31:28] + 4'h4);
  assign prod_q = -($signed(sample_q) * lo_sin(lo_phase_q[31:28]));

  always_ff @(posedge i_clock) begin
    if (i_rst || sync_sync_q[1]) begin
      lo_phase_q <= 32'h0000_0000;
      mix_i_q    <= 16'sh0000;
      mix_q_q    <= 16'sh0000;
    end else begin
      lo_phase_q <= lo_phase_q + tune_q;
      mix_i_q    <= prod_i[30:15];
      mix_q_q    <= prod_q[30:15];
    end
  end

  // decimating filter: coefficient-weighted integrate and dump
  logic [15:0]        dec_cnt_q;
  logic signed [55:0] acc_i_q;
  logic signed [55:0] acc_q_q;
  logic signed [33:0] tap_i;
  logic signed [33:0] tap_q;
  logic               dump;
  logic signed [23:0] dec_i_q;
  logic signed [23:0] dec_q_q;
  logic               dec_vld_q;

  // a factor lowered below the running count dumps at once, never wraps
  assign dump  = (dec_cnt_q >= decim_q - 16'h0001);
  assign tap_i = mix_i_q * $signed(coef_q[dec_cnt_q[CW-1:0]]);
  assign tap_q = mix_q_q * $signed(coef_q[dec_cnt_q[CW-1:0]]);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dec_cnt_q <= 16'h0000;
      acc_i_q   <= '0;
      acc_q_q   <= '0;
      dec_i_q   <= '0;
      dec_q_q   <= '0;
      dec_vld_q <= 1'b0;
    end else begin
      dec_vld_q <= dump;
      if (dump) begin
        dec_cnt_q <= 16'h0000;
        acc_i_q   <= 56'(tap_i);
        acc_q_q   <= 56'(tap_q);
        dec_i_q   <= acc_i_q[47:24];
        dec_q_q   <= acc_q_q[47:24];
      end else begin
        dec_cnt_q <= dec_cnt_q + 16'h0001;
        acc_i_q   <= acc_i_q + 56'(tap_i);
        acc_q_q   <= acc_q_q + 56'(tap_q);
      end
    end
  end

  // phase and gain correction, gain 16'h4000 is unity
  logic signed [39:0] cor_i;
  logic signed [40:0] cor_q;
  logic signed [23:0] out_i_q;
  logic signed [23:0] out_q_q;
  logic               out_vld_q;
  assign cor_i = dec_i_q * $signed(gain_i_q);
  assign cor_q = 41'(dec_q_q * $signed(gain_q_q)) +
                 41'(dec_i_q * $signed(phase_q));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_i_q   <= '0;
      out_q_q   <= '0;
      out_vld_q <= 1'b0;
    end else begin
      out_vld_q <= dec_vld_q;
      if (dec_vld_q) begin
        out_i_q <= cor_i[37:14];
        out_q_q <= cor_q[37:14];
      end
    end
  end

  // power meter over 2^avg samples
  logic [31:0] pw_i;
  logic [31:0] pw_q;
  logic [45:0] pw_acc_q;
  logic [13:0] pw_cnt_q;
  logic        pw_done;
  logic        pw_new_q;
  assign pw_i    = 32'($signed(out_i_q[23:8]) * $signed(out_i_q[23:8]));
  assign pw_q    = 32'($signed(out_q_q[23:8]) * $signed(out_q_q[23:8]));
  // a shortened interval closes at once instead of counting round
  assign pw_done = out_vld_q && (pw_cnt_q >= 14'((1 << avg_q) - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pw_acc_q <= '0;
      pw_cnt_q <= '0;
      power_q  <= 32'h0000_0000;
      pw_new_q <= 1'b0;
    end else begin
      pw_new_q <= pw_done;
      if (pw_done) begin
        power_q  <= 32'((pw_acc_q + 46'(pw_i) + 46'(pw_q)) >> avg_q);
        pw_acc_q <= '0;
        pw_cnt_q <= '0;
      end else if (out_vld_q) begin
        pw_acc_q <= pw_acc_q + 46'(pw_i) + 46'(pw_q);
        pw_cnt_q <= pw_cnt_q + 14'h0001;
      end
    end
  end

  // capture control
  cap_state_t  cap_q;
  logic        capturing;
  logic        gate_fall;
  logic        fifo_ready;
  logic        push;
  logic [31:0] time_q;
  logic [31:0] len_q;
  logic [31:0] t0_q;
  logic        above_q;

  assign capturing = (cap_q == CAP_RUN) &&
                     (!ctrl_q[CTRL_GATEMODE] || gate_sync_q[1]);
  assign push      = capturing && out_vld_q;
  assign gate_fall = gate_d1_q && !gate_sync_q[1];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cap_q <= CAP_IDLE;
    end else begin
      unique case (cap_q)
        CAP_IDLE: cap_q <= CAP_RUN;
        // one-shot stops at the end of the gate, or when the buffer fills
        CAP_RUN: if (ctrl_q[CTRL_ONESHOT] &&
                     (gate_fall || (push && !fifo_ready)))
                   cap_q <= CAP_DONE;
        CAP_DONE: if (ctrl_q[CTRL_REARM] || !ctrl_q[CTRL_ONESHOT])
                    cap_q <= CAP_IDLE;
      endcase
    end
  end

  // time stamp and gate-bounded length
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      time_q       <= 32'h0000_0000;
      t0_q         <= 32'h0000_0000;
      len_q        <= 32'h0000_0000;
      o_meta_valid <= 1'b0;
      o_meta_chan  <= 8'h00;
      o_meta_time  <= 32'h0000_0000;
      o_meta_len   <= 32'h0000_0000;
    end else begin
      time_q       <= time_q + 32'h0000_0001;
      o_meta_valid <= 1'b0;
      if (gate_sync_q[1] && !gate_d1_q) begin
        t0_q  <= time_q;
        // a word taken on the rising cycle belongs to this gate too
        len_q <= (push && fifo_ready) ? 32'h0000_0001 : 32'h0000_0000;
      end else if (push && fifo_ready) begin
        len_q <= len_q + 32'h0000_0001;
      end
      if (gate_fall && ctrl_q[CTRL_GATEMODE] && ctrl_q[CTRL_META_EN]) begin
        o_meta_valid <= 1'b1;
        o_meta_chan  <= CHANNEL_ID;
        o_meta_time  <= t0_q;
        o_meta_len   <= len_q;
      end
    end
  end

  // sticky status; a hardware set wins over a same-cycle clear
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic            above_now;
  assign above_now = (power_q > thresh_q);
  assign st_set[ST_ABOVE]    = pw_new_q && above_now && !above_q;
  assign st_set[ST_BELOW]    = pw_new_q && !above_now && above_q;
  assign st_set[ST_OVERFLOW] = push && !fifo_ready;
  assign st_set[ST_DONE]     = (cap_q == CAP_RUN) && ctrl_q[CTRL_ONESHOT] &&
                               (gate_fall || (push && !fifo_ready));
  assign st_clr = (wr_en && i_paddr == OFS_STATUS) ? i_pwdata[ST_W-1:0] :
                  {ST_W{1'b0}};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      status_q      <= '0;
      above_q       <= 1'b0;
      o_power_alert <= 1'b0;
      o_bw_slot     <= 2'b00;
    end else begin
      status_q      <= (status_q & ~st_clr) | st_set;
      if (pw_new_q) above_q <= above_now;
      o_power_alert <= |(((status_q & ~st_clr) | st_set) & 4'h3);
      o_bw_slot     <= ctrl_q[CTRL_BW_LSB +: CTRL_BW_W];
    end
  end

  // sample buffer; 16-bit format keeps the top of each component
  logic [47:0] word;
  assign word = ctrl_q[CTRL_FMT16] ?
                {16'h0000, out_i_q[23:8], out_q_q[23:8]} :
                {out_i_q, out_q_q};

  acq_fifo #(
    .WIDTH (48),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (word),
    .o_out_valid (o_data_valid),
    .i_out_ready (i_data_ready),
    .o_out_data  (o_data)
  );

endmodule // acq_channel

`default_nettype wire

//--- hdl/acq_fifo.sv
/*
  acq_fifo: synchronous FIFO with a registered output stage.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module acq_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push       = i_in_valid && o_in_ready;
  // the output register refills whenever it is empty or being taken
  assign pop        = (cnt_q != '0) && (!o_out_valid || i_out_ready);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop)  rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (pop) begin
      o_out_valid <= 1'b1;
      o_out_data  <= mem_q[rd_q];
    end else if (i_out_ready) begin
      o_out_valid <= 1'b0;
    end
  end

endmodule // acq_fifo

`default_nettype wire

//--- hdl/acq_pkg.sv
/*
  acq_pkg: register map, field positions, reset values and states of the
  acquisition channel. Assumes a 32-bit APB slave with word-aligned registers.
*/
`default_nettype none

package acq_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_TUNE   = 12'h004;
  localparam logic [11:0] OFS_DECIM  = 12'h008;
  localparam logic [11:0] OFS_GAIN   = 12'h00C;
  localparam logic [11:0] OFS_PHASE  = 12'h010;
  localparam logic [11:0] OFS_AVG    = 12'h014;
  localparam logic [11:0] OFS_THRESH = 12'h018;
  localparam logic [11:0] OFS_POWER  = 12'h01C;
  localparam logic [11:0] OFS_STATUS = 12'h020;
  localparam logic [11:0] OFS_COEF   = 12'h080;

  // control fields
  localparam int CTRL_SEL_LSB   = 0;
  localparam int CTRL_SEL_W     = 4;
  localparam int CTRL_ONESHOT   = 4;
  localparam int CTRL_FMT16     = 5;
  localparam int CTRL_GATEMODE  = 6;
  localparam int CTRL_META_EN   = 7;
  localparam int CTRL_REARM     = 8;
  localparam int CTRL_BW_LSB    = 9;
  localparam int CTRL_BW_W      = 2;

  // status fields, write one to clear
  localparam int ST_ABOVE    = 0;
  localparam int ST_BELOW    = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_DONE     = 3;
  localparam int ST_W        = 4;

  // source select code of the test generator
  localparam logic [3:0] SEL_TEST = 4'h8;

  // reset values
  localparam logic [10:0] CTRL_RST   = 11'h000;
  localparam logic [31:0] TUNE_RST   = 32'h0000_0000;
  localparam logic [15:0] DECIM_RST  = 16'h0002;
  localparam logic [15:0] GAIN_RST   = 16'h4000;
  localparam logic [15:0] PHASE_RST  = 16'h0000;
  localparam logic [3:0]  AVG_RST    = 4'hA;
  localparam logic [31:0] THRESH_RST = 32'h0000_0000;
  localparam logic [17:0] COEF_RST   = 18'h0_4000;

  // limits and the test generator step
  localparam logic [15:0] DECIM_MIN = 16'h0002;
  localparam logic [15:0] DECIM_MAX = 16'h8000;
  localparam logic [3:0]  AVG_MAX   = 4'hD;
  localparam logic [15:0] TEST_STEP = 16'h0101;

  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_RUN,
    CAP_DONE
  } cap_state_t;

endpackage : acq_pkg

`default_nettype wire

//--- sim/acq_channel_chk.sv
/*
  acq_channel_chk: port-level assertions for one acquisition channel.
  Assumes one sample clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module acq_channel_chk #(
  parameter logic [7:0] CHANNEL_ID = 8'h00
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  // stream and metadata
  input  wire logic        o_data_valid,
  input  wire logic        i_data_ready,
  input  wire logic [47:0] o_data,
  input  wire logic        o_meta_valid,
  input  wire logic [7:0]  o_meta_chan,
  input  wire logic [31:0] o_meta_time,
  input  wire logic [31:0] o_meta_len,
  input  wire logic        o_power_alert
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no answer one cycle after setup");
  apb_single_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  data_hold_a: assert property (o_data_valid && !i_data_ready |=>
    o_data_valid && $stable(o_data))
    else $error("stalled sample dropped or changed");
  meta_pulse_a: assert property (o_meta_valid |=> !o_meta_valid)
    else $error("metadata valid longer than one cycle");
  meta_chan_a: assert property (o_meta_valid |-> o_meta_chan == CHANNEL_ID)
    else $error("metadata channel id wrong");
  meta_stand_a: assert property (!o_meta_valid |->
    $stable(o_meta_len) && $stable(o_meta_time))
    else $error("metadata fields changed without pulse");
  reset_clear_a: assert property ($fell(i_rst) |->
    !o_data_valid && !o_meta_valid && !o_power_alert)
    else $error("outputs not cleared by reset");
endmodule // acq_channel_chk

bind acq_channel acq_channel_chk #(.CHANNEL_ID(CHANNEL_ID)) i_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_data_valid(o_data_valid), .i_data_ready(i_data_ready),
  .o_data(o_data), .o_meta_valid(o_meta_valid),
  .o_meta_chan(o_meta_chan), .o_meta_time(o_meta_time),
  .o_meta_len(o_meta_len), .o_power_alert(o_power_alert));

`default_nettype wire

//--- sim/acq_channel_tb.sv
/*
  acq_channel_tb: register, stream, gate and metadata tests of one channel.
  Assumes the sink model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module acq_channel_tb;
  import acq_pkg::*;
  localparam logic [7:0] CHAN = 8'h5A;  // arbitrary channel number
  logic         clk = 1'b0, rst = 1'b1, gate = 1'b0, stall = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0, prdata, q, mtime, mlen, mt [2];
  logic [127:0] adc = 128'h0;
  logic         pready, pslverr, dvalid, dready, mvalid, alert;
  logic [47:0]  data;
  logic [7:0]   mchan;
  logic [1:0]   bw;
  int           cnt, c0, failures = 0, check_count = 0, mn = 0;
  logic [11:0]  ofs [10] = '{OFS_CTRL, OFS_TUNE, OFS_DECIM, OFS_GAIN,
    OFS_PHASE, OFS_AVG, OFS_THRESH, OFS_POWER, OFS_STATUS, OFS_COEF};
  logic [31:0]  rv [10] = '{32'h0, 32'h0, 32'h2, 32'h4000_4000, 32'h0,
    32'hA, 32'h0, 32'h0, 32'h0, 32'h4000};

  always #25 clk = ~clk;

  acq_channel #(.CHANNEL_ID(CHAN)) i_dut (.i_clock(clk), .i_rst(rst),
    .i_adc_data(adc), .i_gate(gate), .i_sync(1'b0), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_data_valid(dvalid), .i_data_ready(dready),
    .o_data(data), .o_meta_valid(mvalid), .o_meta_chan(mchan),
    .o_meta_time(mtime), .o_meta_len(mlen), .o_power_alert(alert),
    .o_bw_slot(bw));
  acq_sink i_sink (.i_clock(clk), .i_rst(rst), .i_valid(dvalid),
    .i_stall(stall), .o_ready(dready), .o_count(cnt));

  always @(posedge clk) begin
    if (mvalid === 1'b1) begin
      if (mn < 2) mt[mn] = mtime;
      mn++;
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] g, input logic [47:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // one transfer; the master never assumes the answer latency
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(ofs[i]);
      chk(q, rv[i]);
    end
    xfer(1'b0, 12'h040, 32'h0);
    chk(e, 1'b1);
    wr(OFS_POWER, 32'hFFFF_FFFF);
    rd(OFS_POWER);
    chk(q, 32'h0);
    wr(OFS_DECIM, 32'h1);
    rd(OFS_DECIM);
    chk(q, 32'h2);
    wr(OFS_DECIM, 32'hFFFF);
    rd(OFS_DECIM);
    chk(q, 32'h8000);
    wr(OFS_AVG, 32'hF);
    rd(OFS_AVG);
    chk(q, 32'hD);
    wr(OFS_TUNE, 32'hFFFF_FFFF);
    rd(OFS_TUNE);
    chk(q, 32'hFFFF_FFFF);
    wr(OFS_TUNE, 32'h0);
    wr(OFS_COEF + 12'h07C, 32'hFFFF_FFFF);
    rd(OFS_COEF + 12'h07C);
    chk(q, 32'h3_FFFF);
    wr(OFS_COEF + 12'h07C, 32'h4000);
    for (int s = 0; s < 9; s++) begin
      wr(OFS_CTRL, 32'(s));
      rd(OFS_CTRL);
      chk(q, 48'(s));
    end
    // test generator, 16-bit format, bandwidth slot 3
    wr(OFS_CTRL, 32'h628);
    wr(OFS_DECIM, 32'h4);
    chk(bw, 2'h3);
    repeat (20) @(posedge clk);
    c0 = cnt;
    repeat (400) begin
      @(posedge clk);
      if (dvalid === 1'b1) chk(data[47:32], 48'h0);
    end
    chk(48'(cnt - c0), 48'h64);
    // full-scale negative input keeps the top 16 bits of I at -1
    adc <= 128'h8000;
    wr(OFS_CTRL, 32'h620);
    wr(OFS_AVG, 32'h0);
    repeat (50) @(posedge clk);
    rd(OFS_POWER);
    chk(q != 32'h0, 1'b1);
    chk(alert, 1'b1);
    wr(OFS_THRESH, 32'hFFFF_FFFF);
    repeat (50) @(posedge clk);
    rd(OFS_STATUS);
    chk(q[1:0], 2'h3);
    wr(OFS_STATUS, 32'h3);
    repeat (10) @(posedge clk);
    chk(alert, 1'b0);
    wr(OFS_CTRL, 32'h0C8);
    repeat (20) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      c0 = cnt;
      gate <= 1'b1;
      repeat (40) @(posedge clk);
      gate <= 1'b0;
      repeat (60) @(posedge clk);
      chk(48'(mlen), 48'(cnt - c0));
      chk(mchan, CHAN);
    end
    chk(48'(mn), 48'h2);
    chk(mt[1] - mt[0], 48'h64);
    // one-shot into a stalled buffer must stop when the FIFO fills
    stall <= 1'b1;
    wr(OFS_CTRL, 32'h018);
    repeat (300) @(posedge clk);
    rd(OFS_STATUS);
    chk(q[3:2], 2'h3);
    stall <= 1'b0;
    c0 = cnt;
    repeat (80) @(posedge clk);
    chk((cnt - c0) >= 32 && (cnt - c0) <= 33, 1'b1);
    c0 = cnt;
    repeat (80) @(posedge clk);
    chk(48'(cnt - c0), 48'h0);
    wr(OFS_STATUS, 32'hC);
    rd(OFS_STATUS);
    chk(q[3:2], 2'h0);
    c0 = cnt;
    wr(OFS_CTRL, 32'h118);
    repeat (80) @(posedge clk);
    chk(48'(cnt - c0 > 10), 48'h1);
    finish_test();
  end
endmodule // acq_channel_tb

`default_nettype wire

//--- sim/acq_sink.sv
/*
  acq_sink: memory buffer side of the sample stream, counts words taken.
  Assumes valid/ready on the channel's sample clock.
*/
`timescale 1ns/1ps
`default_nettype none

module acq_sink (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // stream
  input  wire logic i_valid,
  input  wire logic i_stall,
  output logic      o_ready,
  output int        o_count
);
  // ready lags the stall request by one edge, like a real buffer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_ready <= 1'b0;
      o_count <= 0;
    end else begin
      o_ready <= !i_stall;
      if (i_valid && o_ready) o_count <= o_count + 1;
    end
  end
endmodule // acq_sink

`default_nettype wire
